// ---- core/ops_pkg.sv ----
/*
  Package for the display controller reset-state block: register offsets,
  field positions, reset values and the configuration carrier struct.
  Assumes a single 100 MHz clock domain and a plain strobe register port.
*/
package ops_pkg;

  // Register port widths
  localparam int OPS_ADDR_W = 8;
  localparam int OPS_DATA_W = 16;

  // Geometry widths: 480 columns need 9 bits, 128 rows need 7 bits as a line number and 8 as a count
  localparam int OPS_COL_W = 9;
  localparam int OPS_ROW_W = 7;
  localparam int OPS_GEO_ROW_W = 8;

  // Register offsets (byte addresses)
  localparam logic [OPS_ADDR_W-1:0] OPS_CTRL_OFS = 8'h00;
  localparam logic [OPS_ADDR_W-1:0] OPS_CONTRAST_OFS = 8'h04;
  localparam logic [OPS_ADDR_W-1:0] OPS_START_OFS = 8'h08;
  localparam logic [OPS_ADDR_W-1:0] OPS_COLADDR_OFS = 8'h0C;
  localparam logic [OPS_ADDR_W-1:0] OPS_COLS_OFS = 8'h10;
  localparam logic [OPS_ADDR_W-1:0] OPS_ROWS_OFS = 8'h14;
  localparam logic [OPS_ADDR_W-1:0] OPS_DATA_OFS = 8'h18;
  localparam logic [OPS_ADDR_W-1:0] OPS_STATUS_OFS = 8'h1C;

  // Control register bit positions
  localparam int OPS_CTRL_ON_BIT = 0;
  localparam int OPS_CTRL_SEG_BIT = 1;
  localparam int OPS_CTRL_ROWMAP_BIT = 2;
  localparam int OPS_CTRL_SCAN_BIT = 3;

  // Status register bit positions
  localparam int OPS_STAT_INIT_BIT = 0;
  localparam int OPS_STAT_ON_BIT = 1;

  // Reset values
  localparam logic [7:0] OPS_CONTRAST_RST = 8'h7F;
  localparam logic [OPS_COL_W-1:0] OPS_COLS_RST = 9'h1E0;
  localparam logic [OPS_GEO_ROW_W-1:0] OPS_ROWS_RST = 8'h80;
  localparam logic [OPS_ROW_W-1:0] OPS_START_RST = 7'h00;
  localparam logic [OPS_COL_W-1:0] OPS_COLADDR_RST = 9'h000;

  // Configuration carried to the panel drivers
  typedef struct packed {
    logic display_on;
    logic seg_remap;
    logic row_remap;
    logic scan_rev;
    logic [7:0] contrast;
    logic [OPS_ROW_W-1:0] start_line;
    logic [OPS_COL_W-1:0] col_addr;
    logic [OPS_COL_W-1:0] cols;
    logic [OPS_GEO_ROW_W-1:0] rows;
  } ops_cfg_t;

endpackage

// ---- core/ops_sync.sv ----
/*
  Two-flop synchroniser for one pin level.
  Assumes the pin is asynchronous to clk; reset value is a parameter.
*/
`timescale 1ns/1ps
module ops_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);

  // First stage, read only by the second
  logic meta_q;

  // Two stages, synchronous reset to the inactive level
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// ---- core/ops_ctrl.sv ----
/*
  Display controller reset-state and configuration block. Holds display on,
  mapping, scan direction, contrast, start line, column counter and
  geometry, all forced to defaults while the init pin is low.
  Assumes one 100 MHz clock MCLK, synchronous active-low RST_N, and a host
  that keeps its own supply ordering around this block.
*/
// Chosen here: the placing of the registers and strobed register access.
//
// Overview of operation
// - Init pin low forces panel output off
// - Reset selects 480 by 128 geometry
// - Reset selects normal segment and row mapping
// - Reset sets display start line zero
// - Reset clears column address counter
// - Reset selects normal row scan direction
// - Reset loads contrast with 7F hex
//
`timescale 1ns/1ps
module ops_ctrl
  import ops_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic INIT_IN_N,
  input wire logic [OPS_ADDR_W-1:0] ADDR,
  input wire logic [OPS_DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [OPS_DATA_W-1:0] RDATA,
  output ops_cfg_t CFG,
  output logic INIT_ACTIVE
);

  //////////////////////////////////////////////////////////////////////////
  // Init pin synchronisation

  // Synchronised init level, high when idle
  logic init_s;
  // Controller held in default state
  logic init_low;

  ops_sync #(
    .RST_VAL(1'b1)
  ) u_init_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .d(INIT_IN_N),
    .q(init_s)
  );

  assign init_low = !init_s;

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  // Column counter step, wrapping at the last column of the geometry
  function automatic logic [OPS_COL_W-1:0] col_next(
    input logic [OPS_COL_W-1:0] cur,
    input logic [OPS_COL_W-1:0] cols
  );
    logic [OPS_COL_W-1:0] last;
    last = cols - 9'h001;
    if (cur >= last)
      col_next = OPS_COLADDR_RST;
    else
      col_next = cur + 9'h001;
  endfunction

  // Register decode hit
  function automatic logic hit(
    input logic [OPS_ADDR_W-1:0] a,
    input logic [OPS_ADDR_W-1:0] ofs
  );
    hit = (a == ofs);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Configuration state

  // Registered configuration and its next value
  ops_cfg_t cfg_q;
  ops_cfg_t cfg_d;
  // Read data register and its next value
  logic [OPS_DATA_W-1:0] rdata_q;
  logic [OPS_DATA_W-1:0] rdata_d;

  // Default state image, used by both resets
  function automatic ops_cfg_t cfg_default();
    ops_cfg_t c;
    c.display_on = 1'b0;
    c.seg_remap = 1'b0;
    c.row_remap = 1'b0;
    c.scan_rev = 1'b0;
    c.contrast = OPS_CONTRAST_RST;
    c.start_line = OPS_START_RST;
    c.col_addr = OPS_COLADDR_RST;
    c.cols = OPS_COLS_RST;
    c.rows = OPS_ROWS_RST;
    cfg_default = c;
  endfunction

  // Next configuration: init pin wins over any register write
  always_comb
  begin
    cfg_d = cfg_q;
    if (init_low)
    begin
      // Defaults while the pin is low; writes are dropped
      cfg_d = cfg_default();
    end
    else if (WR)
    begin
      if (hit(ADDR, OPS_CTRL_OFS))
      begin
        cfg_d.display_on = WDATA[OPS_CTRL_ON_BIT];
        cfg_d.seg_remap = WDATA[OPS_CTRL_SEG_BIT];
        cfg_d.row_remap = WDATA[OPS_CTRL_ROWMAP_BIT];
        cfg_d.scan_rev = WDATA[OPS_CTRL_SCAN_BIT];
      end
      else if (hit(ADDR, OPS_CONTRAST_OFS))
        cfg_d.contrast = WDATA[7:0];
      else if (hit(ADDR, OPS_START_OFS))
        cfg_d.start_line = WDATA[OPS_ROW_W-1:0];
      else if (hit(ADDR, OPS_COLADDR_OFS))
      begin
        // Out-of-range column is clamped to zero
        if (WDATA[OPS_COL_W-1:0] < cfg_q.cols)
          cfg_d.col_addr = WDATA[OPS_COL_W-1:0];
        else
          cfg_d.col_addr = OPS_COLADDR_RST;
      end
      else if (hit(ADDR, OPS_COLS_OFS))
      begin
        // Zero columns would let the counter run through all 512 columns; keep old value
        if (WDATA[OPS_COL_W-1:0] != 9'h000)
          cfg_d.cols = WDATA[OPS_COL_W-1:0];
      end
      else if (hit(ADDR, OPS_ROWS_OFS))
      begin
        if (WDATA[OPS_GEO_ROW_W-1:0] != 8'h00)
          cfg_d.rows = WDATA[OPS_GEO_ROW_W-1:0];
      end
      else if (hit(ADDR, OPS_DATA_OFS))
        cfg_d.col_addr = col_next(cfg_q.col_addr, cfg_q.cols);
    end
  end

  // Read mux, answered in the next cycle only
  always_comb
  begin
    rdata_d = '0;
    if (RD)
    begin
      case (ADDR)
        OPS_CTRL_OFS:
        begin
          rdata_d[OPS_CTRL_ON_BIT] = cfg_q.display_on;
          rdata_d[OPS_CTRL_SEG_BIT] = cfg_q.seg_remap;
          rdata_d[OPS_CTRL_ROWMAP_BIT] = cfg_q.row_remap;
          rdata_d[OPS_CTRL_SCAN_BIT] = cfg_q.scan_rev;
        end
        OPS_CONTRAST_OFS: rdata_d[7:0] = cfg_q.contrast;
        OPS_START_OFS: rdata_d[OPS_ROW_W-1:0] = cfg_q.start_line;
        OPS_COLADDR_OFS: rdata_d[OPS_COL_W-1:0] = cfg_q.col_addr;
        OPS_COLS_OFS: rdata_d[OPS_COL_W-1:0] = cfg_q.cols;
        OPS_ROWS_OFS: rdata_d[OPS_GEO_ROW_W-1:0] = cfg_q.rows;
        OPS_STATUS_OFS:
        begin
          rdata_d[OPS_STAT_INIT_BIT] = init_low;
          rdata_d[OPS_STAT_ON_BIT] = cfg_q.display_on;
        end
        // Unmapped and the write-only data port read as zero
        default: rdata_d = '0;
      endcase
    end
  end

  // Register stage, synchronous reset to defaults
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      cfg_q <= cfg_default();
      rdata_q <= '0;
    end
    else
    begin
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  assign CFG = cfg_q;
  assign RDATA = rdata_q;
  assign INIT_ACTIVE = init_low;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  a_init_dark: assert property (@(posedge MCLK) disable iff (!RST_N)
    init_low |=> !cfg_q.display_on)
    else $error("display stayed on during init");

  a_geom_default: assert property (@(posedge MCLK) disable iff (!RST_N)
    init_low |=> (cfg_q.cols == OPS_COLS_RST) && (cfg_q.rows == OPS_ROWS_RST))
    else $error("geometry not default after init");

  a_map_normal: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(init_low) |=> !cfg_q.seg_remap && !cfg_q.row_remap)
    else $error("mapping not normal after init");

  a_start_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
    init_low ##1 init_low |=> cfg_q.start_line == OPS_START_RST)
    else $error("start line not zero after init");

  a_col_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
    init_low |=> cfg_q.col_addr == OPS_COLADDR_RST)
    else $error("column counter not cleared by init");

  a_scan_normal: assert property (@(posedge MCLK) disable iff (!RST_N)
    init_low |=> !cfg_q.scan_rev)
    else $error("scan reversed after init");

  a_contrast_rst: assert property (@(posedge MCLK) disable iff (!RST_N)
    init_low |=> cfg_q.contrast == OPS_CONTRAST_RST)
    else $error("contrast not default after init");

  a_rdata_once: assert property (@(posedge MCLK) disable iff (!RST_N)
    !RD |=> RDATA == '0)
    else $error("read data outside its cycle");

  a_col_wrap: assert property (@(posedge MCLK) disable iff (!RST_N)
    !init_low && WR && hit(ADDR, OPS_DATA_OFS) && (cfg_q.col_addr == cfg_q.cols - 9'h001)
    |=> cfg_q.col_addr == OPS_COLADDR_RST)
    else $error("column counter did not wrap");

endmodule

// ---- testbench/ops_host.sv ----
/*
  Host model that owns the init pin of the controller block.
  Assumes one clock; go is a one-cycle request from the bench.
*/
`timescale 1ns/1ps
module ops_host #(
  parameter int HOLD = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  output logic init_n
);
  // Cycles left with the pin held low
  int cnt_q;
  // Reset pulse on request, as after a corrupted image
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_q <= 0;
    else if (go)
      cnt_q <= HOLD;
    else if (cnt_q > 0)
      cnt_q <= cnt_q - 1;
  end
  // Pin is driven high whenever no pulse is running
  assign init_n = !(cnt_q > 0);
endmodule

// ---- testbench/oled_power_reset_sequencer_tb.sv ----
/*
  Self-checking bench for the controller reset-state block.
  Assumes the host model drives the init pin and the bench the register port.
*/
`timescale 1ns/1ps
module oled_power_reset_sequencer_tb;
  import ops_pkg::*;
  logic MCLK = 0;
  logic RST_N = 0;
  logic WR = 0;
  logic RD = 0;
  logic go = 0;
  logic INIT_IN_N;
  logic INIT_ACTIVE;
  logic [OPS_ADDR_W-1:0] ADDR = '0;
  logic [OPS_DATA_W-1:0] WDATA = '0;
  logic [OPS_DATA_W-1:0] RDATA;
  logic [OPS_DATA_W-1:0] d;
  ops_cfg_t CFG;
  ops_cfg_t e;
  logic [31:0] v;
  int fails = 0;
  int check_count = 0;
  int seed = 32'hceef;
  int c;
  // Panel supply enable; low leaves the supply floating, never grounded
  logic hv_en = 1'b0;
  // Host sequencer done and order-fault indications
  logic seq_done = 1'b0;
  logic seq_fault = 1'b0;
  // Settle and discharge waits, scaled to one cycle per millisecond
  localparam int HV_SETTLE = 200;
  localparam int HV_DISCHARGE = 100;

  ops_ctrl dut (.MCLK(MCLK), .RST_N(RST_N), .INIT_IN_N(INIT_IN_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CFG(CFG), .INIT_ACTIVE(INIT_ACTIVE));
  ops_host host (.clk(MCLK), .rst_n(RST_N), .go(go), .init_n(INIT_IN_N));

  ////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial
    forever #5 MCLK = ~MCLK;

  // Counts, verdict, end of run
  task results;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One comparison, four-state exact
  task chk(input string n, input logic [63:0] x, input logic [63:0] y);
    check_count++;
    if (x !== y)
    begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", n, x, y);
    end
  endtask

  // One-cycle write strobe
  task wr(input logic [7:0] a, input logic [15:0] w);
    @(posedge MCLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= w;
    @(posedge MCLK);
    WR <= 1'b0;
    #1;
  endtask

  // One-cycle read strobe; data stand in the next cycle only
  task rd(input logic [7:0] a);
    @(posedge MCLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask

  // Defaults: off, normal map and scan, contrast 7F, 480 by 128
  function automatic ops_cfg_t dflt();
    ops_cfg_t r;
    r = '0;
    r.contrast = 8'h7F;
    r.cols = 9'h1E0;
    r.rows = 8'h80;
    return r;
  endfunction

  // Host power-up order: display off, contrast and column load, clear, supply, settle, display on
  task power_up;
    wr(OPS_CTRL_OFS, 16'h0000);
    wr(OPS_CONTRAST_OFS, 16'h007F);
    wr(OPS_COLADDR_OFS, 16'h0000);
    for (int k = 0; k < 480; k++)
      wr(OPS_DATA_OFS, 16'h0000);
    chk("clear wrapped", 9'h000, CFG.col_addr);
    chk("dark before supply", 1'b0, CFG.display_on);
    hv_en <= 1'b1;
    repeat (HV_SETTLE) @(posedge MCLK);
    seq_fault = !hv_en;
    wr(OPS_CTRL_OFS, 16'h0001);
    seq_done = CFG.display_on;
    chk("sequence fault", 1'b0, seq_fault);
    chk("sequence done", 1'b1, seq_done);
  endtask

  // Host power-down order: display off, supply off, discharge, logic off
  task power_down;
    wr(OPS_CTRL_OFS, 16'h0000);
    chk("off before supply down", 1'b0, CFG.display_on);
    hv_en <= 1'b0;
    repeat (HV_DISCHARGE) @(posedge MCLK);
    // Logic supply loss seen by the block as a held reset
    RST_N <= 1'b0;
    repeat (6) @(posedge MCLK);
    RST_N <= 1'b1;
    #1 chk("cfg after power cycle", dflt(), CFG);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: far beyond the under two thousand cycles the tests need
  initial
  begin
    #200000;
    fails++;
    results;
  end

  // Main sequence
  initial
  begin
    repeat (6) @(posedge MCLK);
    RST_N <= 1'b1;
    #1 chk("cfg after reset", dflt(), CFG);
    rd(OPS_CONTRAST_OFS);
    chk("contrast read", 16'h007F, d);
    rd(8'h40);
    chk("unmapped read", 16'h0000, d);
    rd(OPS_COLS_OFS);
    chk("cols read", 16'h01E0, d);
    rd(OPS_ROWS_OFS);
    chk("rows read", 16'h0080, d);
    for (int i = 0; i < 8; i++)
    begin
      v = $random(seed);
      c = v[31:23] % 480;
      e = dflt();
      {e.scan_rev, e.row_remap, e.seg_remap, e.display_on} = v[3:0];
      e.contrast = v[11:4];
      e.start_line = v[18:12];
      e.col_addr = c[8:0];
      wr(OPS_CTRL_OFS, {12'h000, v[3:0]});
      wr(OPS_CONTRAST_OFS, {8'h00, v[11:4]});
      wr(OPS_START_OFS, {9'h000, v[18:12]});
      wr(OPS_COLADDR_OFS, c[15:0]);
      chk("cfg written", e, CFG);
      @(posedge MCLK);
      go <= 1'b1;
      @(posedge MCLK);
      go <= 1'b0;
      // Look just after each edge, except the first look, made in the time step of the edge that drops go
      for (int k = 0; k < 20 && INIT_ACTIVE !== 1'b1; k++)
      begin
        @(posedge MCLK);
        #1;
      end
      chk("init active", 1'b1, INIT_ACTIVE);
      @(posedge MCLK);
      #1 chk("cfg in init", dflt(), CFG);
      wr(OPS_CTRL_OFS, 16'h0001);
      chk("on during init", 1'b0, CFG.display_on);
      rd(OPS_STATUS_OFS);
      chk("status init", 1'b1, d[OPS_STAT_INIT_BIT]);
      for (int k = 0; k < 20 && INIT_ACTIVE !== 1'b0; k++)
      begin
        @(posedge MCLK);
        #1;
      end
      chk("init released", 1'b0, INIT_ACTIVE);
    end
    // Column counter: wrap, out-of-range load, advance
    wr(OPS_COLADDR_OFS, 16'h01DF);
    wr(OPS_DATA_OFS, 16'h00A5);
    chk("col wrap", 9'h000, CFG.col_addr);
    wr(OPS_COLADDR_OFS, 16'h01E0);
    chk("col range", 9'h000, CFG.col_addr);
    wr(OPS_COLADDR_OFS, 16'h0005);
    wr(OPS_DATA_OFS, 16'h005A);
    chk("col step", 9'h006, CFG.col_addr);
    // Geometry writes: zero columns refused, row count taken
    wr(OPS_COLS_OFS, 16'h0000);
    chk("cols zero refused", 9'h1E0, CFG.cols);
    wr(OPS_ROWS_OFS, 16'h0040);
    chk("rows written", 8'h40, CFG.rows);
    power_down;
    power_up;
    results;
  end
endmodule
